// [rtl/intc_pkg.sv]
// Purpose: shared constants for the interrupt control and status block
// Assumes: 16-bit byte offsets, 32-bit registers, one word per register
// Notes:   every offset, field position, mask and reset value lives here
package intc_pkg;
    // register base offsets
    localparam logic [15:0] OFS_CONTROL   = 16'h1000;
    localparam logic [15:0] OFS_STATE     = 16'h1010;
    localparam logic [15:0] OFS_RELOAD    = 16'h1020;
    localparam logic [15:0] OFS_FLAG      = 16'h1030;
    localparam logic [15:0] OFS_PRIO_7    = 16'h1100;
    localparam logic [15:0] OFS_PRIO_8    = 16'h1110;
    localparam logic [15:0] OFS_PRIO_9    = 16'h1120;
    localparam logic [15:0] OFS_PRIO_10   = 16'h1130;
    localparam logic [15:0] OFS_EVT_STAT  = 16'h1200;
    localparam logic [15:0] OFS_EVT_MASK  = 16'h1210;
    // alias kinds, taken from address bits 3-2 above a base
    localparam logic [1:0]  ALIAS_NONE    = 2'h0;
    localparam logic [1:0]  ALIAS_CLR     = 2'h1;
    localparam logic [1:0]  ALIAS_SET     = 2'h2;
    localparam logic [1:0]  ALIAS_INV     = 2'h3;
    // register index codes from the decoder
    localparam logic [3:0]  IDX_CONTROL   = 4'h0;
    localparam logic [3:0]  IDX_STATE     = 4'h1;
    localparam logic [3:0]  IDX_RELOAD    = 4'h2;
    localparam logic [3:0]  IDX_FLAG      = 4'h3;
    localparam logic [3:0]  IDX_PRIO_7    = 4'h4;
    localparam logic [3:0]  IDX_PRIO_8    = 4'h5;
    localparam logic [3:0]  IDX_PRIO_9    = 4'h6;
    localparam logic [3:0]  IDX_PRIO_10   = 4'h7;
    localparam logic [3:0]  IDX_EVT_STAT  = 4'h8;
    localparam logic [3:0]  IDX_EVT_MASK  = 4'h9;
    // control register fields
    localparam int          MODE_SEL_BIT  = 12;
    localparam int          TRIG_LVL_LSB  = 8;
    localparam int          EP_LSB        = 0;
    localparam int          NUM_EXT       = 5;
    localparam logic [31:0] CONTROL_MASK  = 32'h0000171F;
    // state register fields
    localparam int          REQ_LVL_LSB   = 8;
    localparam int          VECTOR_LSB    = 0;
    // priority words: 3-bit priority over 2-bit subpriority per byte
    localparam logic [31:0] PRIO_MASK     = 32'h1F1F1F1F;
    localparam int          NUM_PRIO      = 4;
    // event status bits: external edges then proximity expiry
    localparam int          NUM_EVT       = 6;
    localparam int          EVT_PROX_BIT  = 5;
    // reset values
    localparam logic [31:0] RESET_WORD    = 32'h00000000;
endpackage

// [rtl/edge_if.sv]
`timescale 1ns/1ps
// Purpose: carrier between the top and the external edge detector
// Assumes: single clock domain on the logic side
// Notes:   polarity goes down, edge pulses come up
interface edge_if;
    logic [4:0] pol;     // one selects rising edge per input
    logic [4:0] pulse;   // one-cycle edge detected
    modport ctrl (output pol, input pulse);
    modport det  (input pol, output pulse);
endinterface

// [rtl/ext_edge_detect.sv]
`timescale 1ns/1ps
// Purpose: synchronise five external interrupt pins and detect edges
// Assumes: pins are asynchronous to core_clk
// Notes:   first sync stage feeds only the second stage
module ext_edge_detect
    import intc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic [NUM_EXT-1:0] pin_in,
    edge_if.det                    eif
);
    // all state of the detector
    typedef struct packed {
        logic [NUM_EXT-1:0] sync1;  // first stage
        logic [NUM_EXT-1:0] sync2;  // second stage
        logic [NUM_EXT-1:0] last;   // previous synced level
        logic [NUM_EXT-1:0] pulse;  // registered edge pulse
    } det_state_t;

    det_state_t st_reg;
    det_state_t st_next;

    // edge selection per input according to polarity
    always_comb begin
        st_next       = st_reg;
        st_next.sync1 = pin_in;
        st_next.sync2 = st_reg.sync1;
        st_next.last  = st_reg.sync2;
        for (int i = 0; i < NUM_EXT; i++) begin
            // rising when polarity one, falling when zero
            if (eif.pol[i]) begin
                st_next.pulse[i] = st_reg.sync2[i] & ~st_reg.last[i];
            end else begin
                st_next.pulse[i] = ~st_reg.sync2[i] & st_reg.last[i];
            end
        end
    end

    // state register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign eif.pulse = st_reg.pulse;
endmodule

// [rtl/interrupt_control_status.sv]
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
// Purpose: interrupt controller configuration, status and priority words
// Assumes: plain register port, read data one cycle after read strobe
// Notes:   alias writes clear, set or invert the base register bits
// Function
// - bit 12 selects multi or single vector
// - trigger field gates proximity timer by priority
// - polarity bits choose rising or falling edges
// - state bits 10-8 show presented priority level
// - state bits 5-0 show presented vector
// - unimplemented bits read back as zero
// - control registers have clear/set/invert aliases
// - state register decodes only its base
// - triggered timer loads the reload value
// - request flags set when sources request
module interrupt_control_status
    import intc_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic [15:0]         addr,
    input  wire logic [31:0]         wdata,
    input  wire logic                wr_en,
    input  wire logic                rd_en,
    output logic [31:0]              rdata,
    input  wire logic [NUM_EXT-1:0]  ext_irq_pin,
    output logic [NUM_EXT-1:0]       ext_edge_pulse,
    input  wire logic [31:0]         src_request,
    input  wire logic                present_valid,
    input  wire logic [5:0]          present_vector,
    input  wire logic [2:0]          present_level,
    input  wire logic                irq_event,
    input  wire logic [2:0]          irq_event_level,
    output logic                     multi_vector_select,
    output logic [2:0]               proximity_trigger_level,
    output logic                     proximity_running,
    output logic                     proximity_expired,
    output logic                     irq
);
    // decoder result
    typedef struct packed {
        logic       hit;    // address maps to a register
        logic [3:0] idx;    // register index
        logic [1:0] kind;   // alias kind
    } dec_t;

    // all state of the block
    typedef struct packed {
        logic [31:0]               control;     // vector mode, trigger, polarity
        logic [2:0]                req_level;   // requested_priority_level
        logic [5:0]                vector_num;  // presented_vector_number
        logic [31:0]               reload;      // proximity_reload_value
        logic [31:0]               flags;       // request_flag
        logic [NUM_PRIO-1:0][31:0] prio;        // priority_ctrl_7 .. 10
        logic [31:0]               count;       // proximity down counter
        logic                      running;     // proximity timer active
        logic                      expired;     // one-cycle expiry pulse
        logic [NUM_EVT-1:0]        evt_stat;    // sticky event bits
        logic [NUM_EVT-1:0]        evt_mask;    // event enables
        logic [NUM_EXT-1:0]        edge_out;    // registered edge pulses
        logic [31:0]               rdata;       // read data register
        logic                      irq;         // interrupt output
    } top_state_t;

    top_state_t st_reg;
    top_state_t st_next;
    dec_t       wr_dec;    // write decode
    dec_t       rd_dec;    // read decode
    edge_if     eif ();    // link to the edge detector

    // map a byte offset to register index and alias kind
    function automatic dec_t decode(input logic [15:0] a);
        dec_t d;
        logic [15:0] base;
        d      = '0;
        base   = {a[15:4], 4'h0};
        d.kind = a[3:2];
        d.hit  = (a[1:0] == 2'h0);
        case (base)
            OFS_CONTROL:  d.idx = IDX_CONTROL;
            OFS_STATE:    d.idx = IDX_STATE;
            OFS_RELOAD:   d.idx = IDX_RELOAD;
            OFS_FLAG:     d.idx = IDX_FLAG;
            OFS_PRIO_7:   d.idx = IDX_PRIO_7;
            OFS_PRIO_8:   d.idx = IDX_PRIO_8;
            OFS_PRIO_9:   d.idx = IDX_PRIO_9;
            OFS_PRIO_10:  d.idx = IDX_PRIO_10;
            OFS_EVT_STAT: d.idx = IDX_EVT_STAT;
            OFS_EVT_MASK: d.idx = IDX_EVT_MASK;
            default:      d.hit = 1'b0;
        endcase
        // base-only registers refuse alias offsets
        if ((d.idx == IDX_STATE || d.idx == IDX_EVT_STAT) && d.kind != ALIAS_NONE) begin
            d.hit = 1'b0;
        end
        return d;
    endfunction

    // apply a plain or alias write to an old value
    function automatic logic [31:0] alias_write(input logic [31:0] old,
                                                input logic [31:0] wd,
                                                input logic [1:0]  kind);
        logic [31:0] r;
        r = old;
        case (kind)
            ALIAS_NONE: r = wd;
            ALIAS_CLR:  r = old & ~wd;
            ALIAS_SET:  r = old | wd;
            ALIAS_INV:  r = old ^ wd;
            default:    r = old;
        endcase
        return r;
    endfunction

    // proximity trigger test for an event level
    function automatic logic prox_trigger(input logic [2:0] trig_lvl,
                                          input logic [2:0] lvl);
        // zero disables, else level one up to the trigger field
        return (trig_lvl != 3'h0) && (lvl != 3'h0) && (lvl <= trig_lvl);
    endfunction

    // slot of a priority word inside the priority array
    function automatic logic [1:0] prio_slot(input logic [3:0] idx);
        logic [3:0] o;
        o = idx - IDX_PRIO_7;
        return o[1:0];
    endfunction

    // edge detector for the external interrupt pins
    ext_edge_detect u_edge (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (ext_irq_pin),
        .eif      (eif)
    );

    assign eif.pol = st_reg.control[EP_LSB +: NUM_EXT];

    // decode both strobes
    always_comb begin
        wr_dec = decode(addr);
        rd_dec = decode(addr);
    end

    // next-state logic
    always_comb begin
        logic [NUM_EVT-1:0] evt_set;
        logic [NUM_EVT-1:0] evt_clr;
        logic [31:0]        flag_w;
        logic [31:0]        mask_w;
        evt_set = '0;
        evt_clr = '0;
        flag_w  = st_reg.flags;
        mask_w  = 32'h0;
        st_next = st_reg;

        // edge pulses pass straight out through a flop
        st_next.edge_out = eif.pulse;
        st_next.expired  = 1'b0;

        // register writes
        if (wr_en && wr_dec.hit) begin
            case (wr_dec.idx)
                IDX_CONTROL: begin
                    // only vector mode, trigger and polarity bits exist
                    st_next.control = alias_write(st_reg.control, wdata, wr_dec.kind)
                                      & CONTROL_MASK;
                end
                IDX_RELOAD: begin
                    st_next.reload = alias_write(st_reg.reload, wdata, wr_dec.kind);
                end
                IDX_FLAG: begin
                    flag_w = alias_write(st_reg.flags, wdata, wr_dec.kind);
                end
                IDX_PRIO_7, IDX_PRIO_8, IDX_PRIO_9, IDX_PRIO_10: begin
                    st_next.prio[prio_slot(wr_dec.idx)] =
                        alias_write(st_reg.prio[prio_slot(wr_dec.idx)], wdata, wr_dec.kind)
                        & PRIO_MASK;
                end
                IDX_EVT_STAT: begin
                    evt_clr = wdata[NUM_EVT-1:0];
                end
                IDX_EVT_MASK: begin
                    mask_w = alias_write({26'h0, st_reg.evt_mask}, wdata, wr_dec.kind);
                    st_next.evt_mask = mask_w[NUM_EVT-1:0]; // keep the six event bits
                end
                default: begin
                    // state register is read only here
                end
            endcase
        end

        // source requests set flags; set beats any clear
        st_next.flags = flag_w | src_request;

        // latch what was handed to the core
        if (present_valid) begin
            st_next.req_level  = present_level;
            st_next.vector_num = present_vector;
        end

        // proximity timer
        if (irq_event && prox_trigger(st_reg.control[TRIG_LVL_LSB +: 3], irq_event_level)) begin
            st_next.count   = st_reg.reload;
            st_next.running = 1'b1;
        end else if (st_reg.running) begin
            if (st_reg.count == 32'h0) begin
                // reached zero: stop and report
                st_next.running = 1'b0;
                st_next.expired = 1'b1;
            end else begin
                st_next.count = st_reg.count - 32'h1;
            end
        end

        // sticky events: set wins over a write-one clear
        evt_set[NUM_EXT-1:0]  = eif.pulse;
        evt_set[EVT_PROX_BIT] = st_reg.expired;
        st_next.evt_stat      = (st_reg.evt_stat & ~evt_clr) | evt_set;
        st_next.irq           = |(st_next.evt_stat & st_next.evt_mask);

        // read data, valid in the cycle after the strobe
        st_next.rdata = 32'h0;
        if (rd_en && rd_dec.hit && rd_dec.kind == ALIAS_NONE) begin
            case (rd_dec.idx)
                IDX_CONTROL:  st_next.rdata = st_reg.control & CONTROL_MASK;
                IDX_STATE:    st_next.rdata = {21'h0, st_reg.req_level, 2'h0,
                                               st_reg.vector_num};
                IDX_RELOAD:   st_next.rdata = st_reg.reload;
                IDX_FLAG:     st_next.rdata = st_reg.flags;
                IDX_PRIO_7, IDX_PRIO_8, IDX_PRIO_9, IDX_PRIO_10: begin
                    st_next.rdata = st_reg.prio[prio_slot(rd_dec.idx)];
                end
                IDX_EVT_STAT: st_next.rdata = {26'h0, st_reg.evt_stat};
                IDX_EVT_MASK: st_next.rdata = {26'h0, st_reg.evt_mask};
                default:      st_next.rdata = 32'h0;
            endcase
        end
    end

    // state register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flops
    assign rdata                   = st_reg.rdata;
    assign ext_edge_pulse          = st_reg.edge_out;
    assign multi_vector_select     = st_reg.control[MODE_SEL_BIT];
    assign proximity_trigger_level = st_reg.control[TRIG_LVL_LSB +: 3];
    assign proximity_running       = st_reg.running;
    assign proximity_expired       = st_reg.expired;
    assign irq                     = st_reg.irq;
endmodule

// [verif/cpu_side_model.sv]
// Purpose: processor core side that presents vectors and raises events
// Assumes: driven from the bench through its two tasks
// Notes:   released data lines show the inverse of their last value
`timescale 1ns/1ps
module cpu_side_model (
    input  logic       core_clk,
    output logic       present_valid,
    output logic [5:0] present_vector,
    output logic [2:0] present_level,
    output logic       irq_event,
    output logic [2:0] irq_event_level
);
    // quiet lines from time zero
    initial begin
        present_valid = 1'b0;
        present_vector = 6'h00;
        present_level = 3'h0;
        irq_event = 1'b0;
        irq_event_level = 3'h0;
    end
    // one-cycle presentation of a vector and its level
    task automatic present(input logic [5:0] v, input logic [2:0] l);
        @(posedge core_clk);
        present_valid <= 1'b1;
        present_vector <= v;
        present_level <= l;
        @(posedge core_clk);
        present_valid <= 1'b0;
        present_vector <= ~v; // stale data never looks valid
        present_level <= ~l;
    endtask
    // one-cycle interrupt event at a given priority
    task automatic fire(input logic [2:0] l);
        @(posedge core_clk);
        irq_event <= 1'b1;
        irq_event_level <= l;
        @(posedge core_clk);
        irq_event <= 1'b0;
        irq_event_level <= ~l;
    endtask
endmodule

// [verif/intc_status_props.sv]
// Purpose: concurrent checks on the register port and timer start
// Assumes: one clock, asynchronous active-high reset
// Notes:   helpers follow the latest presented vector and level
`timescale 1ns/1ps
module intc_status_props
    import intc_pkg::*;
(
    input logic        core_clk,
    input logic        rst,
    input logic [15:0] addr,
    input logic [31:0] wdata,
    input logic        wr_en,
    input logic        rd_en,
    input logic [31:0] rdata,
    input logic        present_valid,
    input logic [5:0]  present_vector,
    input logic [2:0]  present_level,
    input logic        irq_event,
    input logic [2:0]  irq_event_level,
    input logic        multi_vector_select,
    input logic [2:0]  proximity_trigger_level,
    input logic        proximity_running
);
    logic [5:0] last_vector; // latest presented vector
    logic [2:0] last_lvl;    // latest presented level
    // follow presentations seen at the port
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            last_vector <= 6'h00;
            last_lvl <= 3'h0;
        end else if (present_valid) begin
            last_vector <= present_vector;
            last_lvl <= present_level;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // write of a one into the mode bit at an address
    sequence mode_wr(logic [15:0] a);
        wr_en && addr == a && wdata[MODE_SEL_BIT];
    endsequence
    // base read of the state register with no update beside it
    sequence state_rd;
        rd_en && addr == OFS_STATE && !present_valid;
    endsequence
    mode_set_a: assert property (mode_wr(16'h1008) |=> multi_vector_select)
        else $error("set alias left the mode bit clear");
    mode_clear_a: assert property (mode_wr(16'h1004) |=> !multi_vector_select)
        else $error("clear alias left the mode bit set");
    mode_invert_a: assert property (mode_wr(16'h100C) |=>
        multi_vector_select != $past(multi_vector_select)) else $error("mode bit not toggled");
    trig_field_a: assert property (wr_en && addr == OFS_CONTROL |=>
        proximity_trigger_level == $past(wdata[10:8])) else $error("trigger field not written");
    state_zero_a: assert property (rd_en && addr == OFS_STATE |=>
        rdata[31:11] == 21'h0 && rdata[7:6] == 2'h0) else $error("state spare bits not zero");
    state_read_a: assert property (state_rd |=>
        rdata[10:8] == last_lvl && rdata[5:0] == last_vector) else $error("state value wrong");
    state_alias_a: assert property (rd_en && addr[15:4] == 12'h101 && addr[3:0] != 4'h0 |=>
        rdata == 32'h0) else $error("state alias decoded");
    prox_start_a: assert property (irq_event && irq_event_level != 3'h0 &&
        irq_event_level <= proximity_trigger_level |=> proximity_running)
        else $error("timer did not start");
    prox_refuse_a: assert property (irq_event && irq_event_level > proximity_trigger_level
        && !proximity_running |=> !proximity_running) else $error("timer started wrongly");
endmodule
bind interrupt_control_status intc_status_props i_intc_status_props (
    .core_clk                (core_clk),
    .rst                     (rst),
    .addr                    (addr),
    .wdata                   (wdata),
    .wr_en                   (wr_en),
    .rd_en                   (rd_en),
    .rdata                   (rdata),
    .present_valid           (present_valid),
    .present_vector          (present_vector),
    .present_level           (present_level),
    .irq_event               (irq_event),
    .irq_event_level         (irq_event_level),
    .multi_vector_select     (multi_vector_select),
    .proximity_trigger_level (proximity_trigger_level),
    .proximity_running       (proximity_running)
);

// [verif/interrupt_control_status_tb_top.sv]
// Purpose: register level tests of the interrupt control and status block
// Assumes: read data one cycle after the read strobe
// Notes:   the core side is played by a separate model
`timescale 1ns/1ps
module interrupt_control_status_tb_top
    import intc_pkg::*;
();
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wdata = 32'h00000000;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [4:0]  ext_irq_pin = 5'h0A;
    logic [31:0] src_request = 32'h00000000;
    logic [31:0] rdata, r;
    logic [4:0]  ext_edge_pulse, s;
    logic [5:0]  present_vector;
    logic [2:0]  present_level, irq_event_level, proximity_trigger_level;
    logic        present_valid, irq_event, multi_vector_select;
    logic        proximity_running, proximity_expired, irq;
    int          fails = 0;
    int          comparisons = 0;
    int          n;
    logic [15:0] ofs [12] = '{OFS_CONTROL, OFS_STATE, OFS_RELOAD, OFS_FLAG, OFS_PRIO_7,
        OFS_PRIO_8, OFS_PRIO_9, OFS_PRIO_10, OFS_EVT_STAT, OFS_EVT_MASK, 16'h1014, 16'h1FFC};
    always #5 core_clk = ~core_clk;
    interrupt_control_status i_interrupt_control_status (
        .core_clk                (core_clk),
        .rst                     (rst),
        .addr                    (addr),
        .wdata                   (wdata),
        .wr_en                   (wr_en),
        .rd_en                   (rd_en),
        .rdata                   (rdata),
        .ext_irq_pin             (ext_irq_pin),
        .ext_edge_pulse          (ext_edge_pulse),
        .src_request             (src_request),
        .present_valid           (present_valid),
        .present_vector          (present_vector),
        .present_level           (present_level),
        .irq_event               (irq_event),
        .irq_event_level         (irq_event_level),
        .multi_vector_select     (multi_vector_select),
        .proximity_trigger_level (proximity_trigger_level),
        .proximity_running       (proximity_running),
        .proximity_expired       (proximity_expired),
        .irq                     (irq)
    );
    cpu_side_model i_cpu_side_model (
        .core_clk        (core_clk),
        .present_valid   (present_valid),
        .present_vector  (present_vector),
        .present_level   (present_level),
        .irq_event       (irq_event),
        .irq_event_level (irq_event_level)
    );
    // compare and count
    task automatic chk(input logic [31:0] sv, input logic [31:0] ev);
        comparisons++;
        if (sv !== ev) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, sv, ev);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask
    // one-cycle read strobe, data taken in the following cycle
    task automatic rc(input logic [15:0] a, input logic [31:0] e);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 r = rdata;
        chk(r, e);
    endtask
    // wait whole cycles, then step off the edge
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    // move the pins and gather every edge pulse seen
    task automatic edges(input logic [4:0] p);
        s = 5'h00;
        @(posedge core_clk);
        ext_irq_pin <= p;
        repeat (8) begin
            @(posedge core_clk);
            #1 s = s | ext_edge_pulse;
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        end_of_test();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        foreach (ofs[i]) rc(ofs[i], 32'h0);
        wr(OFS_CONTROL, 32'hFFFFFFFF);
        rc(OFS_CONTROL, 32'h0000171F);
        wr(16'h1004, 32'h00001000);
        rc(OFS_CONTROL, 32'h0000071F);
        chk({31'h0, multi_vector_select}, 32'h0);
        wr(16'h1008, 32'h00001000);
        rc(OFS_CONTROL, 32'h0000171F);
        chk({31'h0, multi_vector_select}, 32'h1);
        wr(16'h100C, 32'h00001101);
        rc(OFS_CONTROL, 32'h0000061E);
        chk({29'h0, proximity_trigger_level}, 32'h6);
        chk({31'h0, multi_vector_select}, 32'h0);
        wr(OFS_CONTROL, 32'h00000015);
        for (int i = 0; i < NUM_PRIO; i++) begin
            wr(OFS_PRIO_7 + 16'(i * 16), 32'hFFFFFFFF);
            wr(OFS_PRIO_7 + 16'(i * 16) + 16'h000C, 32'h01010101);
            rc(OFS_PRIO_7 + 16'(i * 16), 32'h1E1E1E1E);
        end
        // state is read only in either vector mode; single vector mode is set here
        i_cpu_side_model.present(6'h2A, 3'h5);
        wr(OFS_STATE, 32'hFFFFFFFF);
        wr(OFS_STATE + 16'h0008, 32'hFFFFFFFF);
        rc(OFS_STATE, 32'h0000052A);
        rc(OFS_STATE + 16'h0008, 32'h0);
        i_cpu_side_model.present(6'h3F, 3'h7);
        rc(OFS_STATE, 32'h0000073F);
        edges(5'h15);
        chk({27'h0, s}, 32'h1F);
        rc(OFS_EVT_STAT, 32'h1F);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_EVT_MASK, 32'h1);
        tick(2);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_EVT_STAT, 32'h1);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        rc(OFS_EVT_STAT, 32'h1E);
        edges(5'h0A);
        chk({27'h0, s}, 32'h0);
        @(posedge core_clk);
        src_request <= 32'h80;
        @(posedge core_clk);
        src_request <= 32'h0;
        rc(OFS_FLAG, 32'h80);
        wr(OFS_FLAG + 16'h0004, 32'h80);
        rc(OFS_FLAG, 32'h0);
        // every trigger setting against event levels one to seven
        for (int t = 0; t < 8; t++) begin
            wr(OFS_CONTROL, 32'(t << 8));
            for (int l = 1; l < 8; l++) begin
                i_cpu_side_model.fire(3'(l));
                #1 chk({31'h0, proximity_running}, 32'((t != 0 && l <= t) ? 1 : 0));
                tick(3);
            end
        end
        wr(OFS_RELOAD, 32'h2);
        wr(OFS_CONTROL, 32'h300);
        i_cpu_side_model.fire(3'h3);
        n = 0;
        while (proximity_expired !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk(32'(n), 32'h3);
        rc(OFS_RELOAD, 32'h2);
        tick(2);
        rc(OFS_EVT_STAT, 32'h3E);
        end_of_test();
    end
endmodule
